// ---- src/sfr_map_indirect_access.v ----
// sfr_map_indirect_access.v: special-function register bank with indirect window
// assumes: the core presents one access per instruction cycle on mclk, with
// the direct address; peripherals supply their read-only values as inputs.
`timescale 1ns/1ps
`default_nettype none
`include "sfr_defines.vh"
module sfr_map_indirect_access #(
  parameter GPR_DEPTH = 64
) (
  // clock and reset
  input  wire        mclk,
  input  wire        resetn,
  // core data access
  input  wire [6:0]  acc_addr,
  input  wire        acc_rd,
  input  wire        acc_wr,
  input  wire [7:0]  acc_wdata,
  output wire [7:0]  acc_rdata,
  // alu flag update from the executing instruction
  input  wire        alu_flag_we,
  input  wire [2:0]  alu_flags,
  // status flags set by the core
  input  wire        timeout_n,
  input  wire        powerdown_n,
  // program counter
  input  wire [10:0] pc_value,
  output wire        pc_low_we,
  output wire [7:0]  pc_low_wdata,
  // peripheral read-only values
  input  wire [5:0]  port_pins,
  input  wire [7:0]  tma_count,
  input  wire [15:0] pwma_count,
  input  wire [7:0]  pwmb_count,
  input  wire [9:0]  adc_result,
  input  wire [7:0]  hw_int_flag_set,
  // register contents to peripherals
  output reg  [5:0]  port_latch_reg,
  output reg  [7:0]  flags_reg,
  output reg  [6:0]  pointer_reg,
  output wire [255:0] sfr_out
);
  // 32-entry array of plain read-write registers 0x07..0x3A, compacted
  reg [7:0] cfg_reg [0:31];
  reg [7:0] int_flag_reg;
  reg [5:0] pins_s1_reg;
  reg [5:0] pins_s2_reg;

  wire        is_window   = (acc_addr == `A_WINDOW);
  // target address from pointer low seven bits
  wire [6:0]  eff_addr    = is_window ? pointer_reg : acc_addr;
  wire        self_window = is_window && (pointer_reg == `A_WINDOW);
  // write to the window through itself goes nowhere
  wire        eff_wr      = acc_wr && !self_window;

  // maps a config address to its array slot and implemented mask; 5'h1F = none
  function [12:0] cfg_slot;
    input [6:0] a;
    begin
      case (a)
        `A_PIN_IE:       cfg_slot = {5'h00, `M_PORT6};
        `A_PIN_EDGE:     cfg_slot = {5'h01, `M_PORT6};
        `A_INT_EN:       cfg_slot = {5'h02, `M_INT_EN};
        `A_TMA_CTRL:     cfg_slot = {5'h03, `M_TMA_CTRL};
        `A_TMA_PRESET:   cfg_slot = {5'h04, 8'hFF};
        `A_WDOG:         cfg_slot = {5'h05, `M_WDOG};
        `A_POWER:        cfg_slot = {5'h06, `M_POWER};
        `A_CLOCK_CONFIGURATION:       cfg_slot = {5'h07, `M_CLOCK_CONFIGURATION};
        `A_PWMA_CFG:     cfg_slot = {5'h08, `M_PWM_CFG};
        `A_PWMA_RUN:     cfg_slot = {5'h09, 8'hFF};
        `A_PWMA_DUTY_LO: cfg_slot = {5'h0A, 8'hFF};
        `A_PWMA_DUTY_HI: cfg_slot = {5'h0B, 8'hFF};
        `A_PWMB_CFG:     cfg_slot = {5'h0C, `M_PWM_CFG};
        `A_PWMB_RUN:     cfg_slot = {5'h0D, 8'hFF};
        `A_PWMB_DUTY:    cfg_slot = {5'h0E, 8'hFF};
        `A_BUZZ_LVD:     cfg_slot = {5'h0F, `M_BUZZ_LVD};
        `A_ADC_CTRL1:    cfg_slot = {5'h10, 8'hFF};
        `A_ADC_CTRL2:    cfg_slot = {5'h11, `M_ADC_CTRL2};
        `A_ADC_INEN:     cfg_slot = {5'h12, `M_ADC_INEN};
        `A_CMP_CTRL1:    cfg_slot = {5'h13, 8'hFF};
        `A_CMP_REF1_HI:  cfg_slot = {5'h14, 8'hFF};
        `A_CMP_REF1_LO:  cfg_slot = {5'h15, `M_REF_LO};
        `A_CMP_CTRL2:    cfg_slot = {5'h16, 8'hFF};
        `A_CMP_REF2_HI:  cfg_slot = {5'h17, 8'hFF};
        `A_CMP_REF2_LO:  cfg_slot = {5'h18, `M_REF_LO};
        default:         cfg_slot = {5'h1F, 8'h00};
      endcase
    end
  endfunction

  wire [12:0] slot_info = cfg_slot(eff_addr);
  wire [4:0]  slot      = slot_info[12:8];
  wire [7:0]  slot_mask = slot_info[7:0];
  wire        slot_hit  = (slot != 5'h1F);
  wire        gpr_hit   = eff_addr[6];

  wire [7:0]  gpr_rdata;
  sfr_gpr_ram #(
    .DEPTH (GPR_DEPTH),
    .AW    (6)
  ) u_gpr (
    .mclk    (mclk),
    .wr_en   (eff_wr && gpr_hit),
    .wr_addr (eff_addr[5:0]),
    .wr_data (acc_wdata),
    .rd_addr (eff_addr[5:0]),
    .rd_data (gpr_rdata)
  );

  // read mux; the answer is combinational within the access cycle
  reg [7:0] rd_mux;
  always @* begin
    rd_mux = `ZERO8;
    if (self_window) begin
      rd_mux = `ZERO8;
    end else if (gpr_hit) begin
      rd_mux = gpr_rdata;
    end else if (slot_hit) begin
      rd_mux = cfg_reg[slot] & slot_mask;
    end else begin
      case (eff_addr)
        `A_PC_LOW:      rd_mux = pc_value[7:0];
        `A_FLAGS:       rd_mux = flags_reg & `M_FLAGS;
        `A_POINTER:     rd_mux = {1'b0, pointer_reg};
        `A_PORT:        rd_mux = {2'b00, pins_s2_reg};
        `A_INT_FLAG:    rd_mux = int_flag_reg & `M_INT_FLAG;
        `A_TMA_COUNT:   rd_mux = tma_count;
        `A_PWMA_CNT_LO: rd_mux = pwma_count[7:0];
        `A_PWMA_CNT_HI: rd_mux = pwma_count[15:8];
        `A_PWMB_CNT:    rd_mux = pwmb_count;
        `A_ADC_HI:      rd_mux = adc_result[9:2];
        `A_ADC_LO:      rd_mux = {6'b000000, adc_result[1:0]};
        default:        rd_mux = `ZERO8;
      endcase
    end
  end
  assign acc_rdata = acc_rd ? rd_mux : `ZERO8;

  // pc low write goes to the core's program counter; pc high bits are never mapped
  assign pc_low_we    = eff_wr && (eff_addr == `A_PC_LOW);
  assign pc_low_wdata = acc_wdata;

  integer i;
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      for (i = 0; i < 32; i = i + 1) begin
        cfg_reg[i] <= `ZERO8;
      end
      flags_reg      <= `FLAGS_RESET;
      pointer_reg    <= 7'h00;
      port_latch_reg <= 6'h00;
      int_flag_reg   <= `ZERO8;
      pins_s1_reg    <= 6'h00;
      pins_s2_reg    <= 6'h00;
    end else begin
      pins_s1_reg <= port_pins;
      pins_s2_reg <= pins_s1_reg;
      if (eff_wr && slot_hit) begin
        cfg_reg[slot] <= acc_wdata & slot_mask;
      end
      if (eff_wr && (eff_addr == `A_POINTER)) begin
        pointer_reg <= acc_wdata[6:0];
      end
      if (eff_wr && (eff_addr == `A_PORT)) begin
        port_latch_reg <= acc_wdata[5:0];
      end
      // hardware set wins over a software write in the same cycle
      int_flag_reg <= ((eff_wr && (eff_addr == `A_INT_FLAG)) ? acc_wdata : int_flag_reg)
                      & `M_INT_FLAG | (hw_int_flag_set & `M_INT_FLAG);
      // timeout and powerdown are not writable; frp only from a write
      flags_reg[5] <= (eff_wr && (eff_addr == `A_FLAGS)) ? acc_wdata[5] : flags_reg[5];
      flags_reg[4] <= timeout_n;
      flags_reg[3] <= powerdown_n;
      flags_reg[7:6] <= 2'b00;
      if (alu_flag_we) begin
        flags_reg[2:0] <= alu_flags;
      end else if (eff_wr && (eff_addr == `A_FLAGS)) begin
        flags_reg[2:0] <= acc_wdata[2:0];
      end
    end
  end

  // read-only registers have no storage here, so writes to them fall away
  genvar g;
  generate
    for (g = 0; g < 32; g = g + 1) begin : g_out
      assign sfr_out[g*8 +: 8] = cfg_reg[g];
    end
  endgenerate
endmodule // sfr_map_indirect_access
`default_nettype wire

// ---- src/sfr_defines.vh ----
// sfr_defines.vh: addresses, implemented-bit masks and reset values of the register bank
// assumes: included by bare name from the design files under src/
`ifndef SFR_DEFINES_VH
`define SFR_DEFINES_VH
`define ADDR_W            7
`define A_WINDOW          7'h00
`define A_PC_LOW          7'h02
`define A_FLAGS           7'h03
`define A_POINTER         7'h04
`define A_PORT            7'h05
`define A_PIN_IE          7'h07
`define A_PIN_EDGE        7'h09
`define A_INT_EN          7'h0B
`define A_INT_FLAG        7'h0C
`define A_TMA_COUNT       7'h0E
`define A_TMA_CTRL        7'h0F
`define A_TMA_PRESET      7'h10
`define A_WDOG            7'h11
`define A_POWER           7'h12
`define A_CLOCK_CONFIGURATION          7'h13
`define A_PWMA_CFG        7'h14
`define A_PWMA_RUN        7'h15
`define A_PWMA_CNT_LO     7'h16
`define A_PWMA_DUTY_LO    7'h17
`define A_PWMA_CNT_HI     7'h18
`define A_PWMA_DUTY_HI    7'h19
`define A_PWMB_CFG        7'h20
`define A_PWMB_RUN        7'h21
`define A_PWMB_CNT        7'h22
`define A_PWMB_DUTY       7'h23
`define A_BUZZ_LVD        7'h24
`define A_ADC_CTRL1       7'h28
`define A_ADC_CTRL2       7'h29
`define A_ADC_HI          7'h30
`define A_ADC_LO          7'h31
`define A_ADC_INEN        7'h32
`define A_CMP_CTRL1       7'h35
`define A_CMP_REF1_HI     7'h36
`define A_CMP_REF1_LO     7'h37
`define A_CMP_CTRL2       7'h38
`define A_CMP_REF2_HI     7'h39
`define A_CMP_REF2_LO     7'h3A
`define A_GPR_BASE        7'h40
// implemented-bit masks, unimplemented positions read zero
`define M_FLAGS           8'h3F
`define M_FLAGS_WR        8'h27
`define M_ALU_FLAGS       8'h07
`define M_POINTER         8'h7F
`define M_PORT6           8'h3F
`define M_INT_EN          8'h99
`define M_INT_FLAG        8'h59
`define M_TMA_CTRL        8'hBE
`define M_WDOG            8'hFC
`define M_POWER           8'h7F
`define M_CLOCK_CONFIGURATION          8'hF7
`define M_PWM_CFG         8'hBF
`define M_BUZZ_LVD        8'hF0
`define M_ADC_CTRL2       8'hDF
`define M_ADC_LO          8'h03
`define M_ADC_INEN        8'h1F
`define M_REF_LO          8'h03
`define FLAGS_RESET       8'h18
`define ZERO8             8'h00
`endif

// ---- src/sfr_gpr_ram.v ----
// sfr_gpr_ram.v: general purpose register array for the upper data addresses
// assumes: one write port, asynchronous read, same clock as the register bank
`timescale 1ns/1ps
`default_nettype none
module sfr_gpr_ram #(
  parameter DEPTH  = 64,
  parameter AW     = 6
) (
  // clock
  input  wire         mclk,
  // write port
  input  wire         wr_en,
  input  wire [AW-1:0] wr_addr,
  input  wire [7:0]   wr_data,
  // read port
  input  wire [AW-1:0] rd_addr,
  output wire [7:0]   rd_data
);
  // contents are undefined at power-up, as for the on-chip sram
  reg [7:0] mem [0:DEPTH-1];

  always @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  assign rd_data = mem[rd_addr];
endmodule // sfr_gpr_ram
`default_nettype wire

// ---- tb/core_model.sv ----
// core_model.sv: instruction datapath side, one access per call
// assumes: caller enters each task just after a rising edge of mclk
`timescale 1ns/1ps
`default_nettype none
module core_model (
  // clock and answer
  input  wire logic       mclk,
  input  wire logic [7:0] acc_rdata,
  // access request
  output logic      [6:0] acc_addr,
  output logic            acc_rd,
  output logic            acc_wr,
  output logic      [7:0] acc_wdata,
  output logic            alu_flag_we,
  output logic      [2:0] alu_flags
);
  initial begin
    acc_addr = 7'h01;
    acc_rd = 1'b0;
    acc_wr = 1'b0;
    acc_wdata = 8'h00;
    alu_flag_we = 1'b0;
    alu_flags = 3'h0;
  end
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    acc_addr = a;
    acc_rd = 1'b1;
    @(posedge mclk);
    d = acc_rdata;
    #1 acc_rd = 1'b0;
    // one idle edge, so a following call never re-raises a strobe in the same time step
    @(posedge mclk);
    #1;
  endtask
  // data bus shows the inverse once released so stale values never match
  task automatic wr(input logic [6:0] a, input logic [7:0] d, input logic fe, input logic [2:0] fl);
    acc_addr = a;
    acc_wdata = d;
    acc_wr = 1'b1;
    alu_flag_we = fe;
    alu_flags = fl;
    @(posedge mclk);
    #1 acc_wr = 1'b0;
    alu_flag_we = 1'b0;
    acc_wdata = ~d;
    @(posedge mclk);
    #1;
  endtask
endmodule // core_model
`default_nettype wire

// ---- tb/sfr_map_sva.sv ----
// sfr_map_sva.sv: port assertions for the register bank
// assumes: bound to sfr_map_indirect_access, one clock mclk
`timescale 1ns/1ps
`default_nettype none
module sfr_map_sva (
  // watched ports
  input wire logic        mclk,
  input wire logic        resetn,
  input wire logic [6:0]  acc_addr,
  input wire logic        acc_rd,
  input wire logic        acc_wr,
  input wire logic [7:0]  acc_wdata,
  input wire logic [7:0]  acc_rdata,
  input wire logic        alu_flag_we,
  input wire logic [2:0]  alu_flags,
  input wire logic [10:0] pc_value,
  input wire logic        pc_low_we,
  input wire logic [7:0]  pc_low_wdata,
  input wire logic [7:0]  tma_count,
  input wire logic [7:0]  flags_reg,
  input wire logic [6:0]  pointer_reg
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  a_ptr_low_seven: assert property (
    acc_wr && acc_addr == 7'h04 |=> pointer_reg == $past(acc_wdata[6:0])) else $error("pointer load");
  a_flags_top_zero: assert property (
    acc_rd && acc_addr == 7'h03 |-> acc_rdata[7:6] == 2'b00) else $error("flags top bits");
  a_self_read_zero: assert property (
    acc_rd && acc_addr == 7'h00 && pointer_reg == 7'h00 |-> acc_rdata == 8'h00) else $error("self read");
  a_window_alias: assert property (
    acc_rd && acc_addr == 7'h00 && pointer_reg == 7'h04 |-> acc_rdata == 8'h04) else $error("alias");
  a_self_write_drop: assert property (
    acc_wr && acc_addr == 7'h00 && pointer_reg == 7'h00 && !alu_flag_we
    |=> $stable(pointer_reg) && $stable(flags_reg[2:0])) else $error("self write");
  a_alu_flags_win: assert property (
    alu_flag_we |=> flags_reg[2:0] == $past(alu_flags)) else $error("alu flags");
  a_pc_low_read: assert property (
    acc_rd && acc_addr == 7'h02 |-> acc_rdata == pc_value[7:0]) else $error("pc read");
  a_pc_low_write: assert property (
    acc_wr && acc_addr == 7'h02 |-> pc_low_we && pc_low_wdata == acc_wdata) else $error("pc write");
  a_timer_read_only: assert property (
    acc_rd && acc_addr == 7'h0E |-> acc_rdata == tma_count) else $error("timer read");
  c_window_read: cover property (acc_rd && acc_addr == 7'h00 && pointer_reg != 7'h00);
  c_self_write: cover property (acc_wr && acc_addr == 7'h00 && pointer_reg == 7'h00);
  c_alu_write: cover property (alu_flag_we && acc_wr && acc_addr == 7'h03);
endmodule // sfr_map_sva
bind sfr_map_indirect_access sfr_map_sva u_sva (.mclk(mclk), .resetn(resetn), .acc_addr(acc_addr),
  .acc_rd(acc_rd), .acc_wr(acc_wr), .acc_wdata(acc_wdata), .acc_rdata(acc_rdata),
  .alu_flag_we(alu_flag_we), .alu_flags(alu_flags), .pc_value(pc_value), .pc_low_we(pc_low_we),
  .pc_low_wdata(pc_low_wdata), .tma_count(tma_count), .flags_reg(flags_reg),
  .pointer_reg(pointer_reg));
`default_nettype wire

// ---- tb/testbench.sv ----
// testbench.sv: directed register access tests of the register bank
// assumes: core_model drives the access port, peripherals are bench values
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        mclk = 1'b0;
  logic        resetn = 1'b0;
  wire  [6:0]  acc_addr;
  wire         acc_rd;
  wire         acc_wr;
  wire  [7:0]  acc_wdata;
  wire  [7:0]  acc_rdata;
  wire         alu_flag_we;
  wire  [2:0]  alu_flags;
  logic [7:0]  d;
  logic        timeout_pin = 1'b1;
  logic [10:0] pc_val = 11'h5A3;
  logic [7:0]  tma_val = 8'h3C;
  logic [7:0]  irq_set = 8'h01;
  int          n_errors = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  logic [6:0]  ro_a [9] = '{7'h0E, 7'h16, 7'h18, 7'h22, 7'h30, 7'h31, 7'h05, 7'h01, 7'h0C};
  logic [7:0]  ro_e [9] = '{8'h3C, 8'h34, 8'h12, 8'h5A, 8'hFF, 8'h03, 8'h15, 8'h00, 8'h01};
  always #2.5 mclk = ~mclk;
  core_model u_core (.mclk(mclk), .acc_rdata(acc_rdata), .acc_addr(acc_addr), .acc_rd(acc_rd),
    .acc_wr(acc_wr), .acc_wdata(acc_wdata), .alu_flag_we(alu_flag_we), .alu_flags(alu_flags));
  sfr_map_indirect_access dut (.mclk(mclk), .resetn(resetn), .acc_addr(acc_addr),
    .acc_rd(acc_rd), .acc_wr(acc_wr), .acc_wdata(acc_wdata), .acc_rdata(acc_rdata),
    .alu_flag_we(alu_flag_we), .alu_flags(alu_flags), .timeout_n(timeout_pin),
    .powerdown_n(1'b1), .pc_value(pc_val), .pc_low_we(), .pc_low_wdata(), .port_pins(6'h15),
    .tma_count(tma_val), .pwma_count(16'h1234), .pwmb_count(8'h5A), .adc_result(10'h3FF),
    .hw_int_flag_set(irq_set),
    .port_latch_reg(), .flags_reg(), .pointer_reg(), .sfr_out());
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic give_verdict;
    $display("checked %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // a hang must not outlive the directed tests, which need well under 200 cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 2000) begin
      n_errors++;
      give_verdict();
    end
  end
  initial begin
    repeat (20) @(posedge mclk);
    #1 resetn = 1'b1;
    u_core.rd(7'h03, d); chk("flags reset", 8'h18, d);
    $display("reset test done");
    u_core.wr(7'h48, 8'h10, 0, 0);
    u_core.wr(7'h49, 8'h0A, 0, 0);
    u_core.wr(7'h04, 8'hC8, 0, 0);
    u_core.rd(7'h04, d); chk("pointer", 8'h48, d);
    u_core.rd(7'h00, d); chk("window 48", 8'h10, d);
    u_core.wr(7'h04, 8'h49, 0, 0);
    u_core.rd(7'h00, d); chk("window 49", 8'h0A, d);
    u_core.wr(7'h00, 8'h77, 0, 0);
    u_core.rd(7'h49, d); chk("window write", 8'h77, d);
    u_core.wr(7'h04, 8'h04, 0, 0);
    u_core.rd(7'h00, d); chk("window alias", 8'h04, d);
    $display("indirect test done");
    u_core.wr(7'h04, 8'h00, 0, 0);
    u_core.rd(7'h00, d); chk("self read", 8'h00, d);
    u_core.wr(7'h00, 8'h55, 0, 0);
    u_core.rd(7'h04, d); chk("self write pointer", 8'h00, d);
    u_core.rd(7'h03, d); chk("self write flags", 8'h18, d);
    $display("self window test done");
    u_core.wr(7'h03, 8'hFF, 0, 0);
    u_core.rd(7'h03, d); chk("flags mask", 8'h3F, d);
    u_core.wr(7'h03, 8'h00, 1, 3'b101);
    u_core.rd(7'h03, d); chk("flags alu", 8'h1D, d);
    u_core.rd(7'h02, d); chk("pc low", 8'hA3, d);
    u_core.wr(7'h02, 8'h11, 0, 0);
    $display("flags and pc test done");
    for (int i = 0; i < 9; i++) begin
      if (i != 8) u_core.wr(ro_a[i], 8'hFF, 0, 0);
      u_core.rd(ro_a[i], d); chk("read only", ro_e[i], d);
    end
    $display("read only test done");
    timeout_pin = 1'b0;
    pc_val = 11'h7FF;
    tma_val = 8'hC3;
    irq_set = 8'h00;
    // status bits take one edge to follow their inputs
    @(posedge mclk);
    #1;
    u_core.rd(7'h03, d); chk("flags timeout", 8'h0D, d);
    u_core.rd(7'h02, d); chk("pc low live", 8'hFF, d);
    u_core.rd(7'h0E, d); chk("timer live", 8'hC3, d);
    u_core.wr(7'h0C, 8'h00, 0, 0);
    u_core.rd(7'h0C, d); chk("irq flag clear", 8'h00, d);
    $display("live input test done");
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
